// *** cmbx_pkg.sv ***
// package of the mailbox code state logic: codes, field positions, update state type, code extractor
// assumes a single 50 MHz core clock shared by both ends
`default_nettype none
package cmbx_pkg;
    localparam int CMBX_CODE_MSB = 27;
    localparam int CMBX_CODE_LSB = 24;
    localparam int CMBX_RTR_BIT = 20;
    localparam int CMBX_FD_FLAG_BIT = 31;
    localparam logic [3:0] CODE_RX_INACTIVE = 4'h0;
    localparam logic [3:0] CODE_RX_EMPTY = 4'h4;
    localparam logic [3:0] CODE_RX_FULL = 4'h2;
    localparam logic [3:0] CODE_RX_OVERRUN = 4'h6;
    localparam logic [3:0] CODE_ANSWER_WAIT = 4'hA;
    localparam logic [3:0] CODE_TX_INACTIVE = 4'h8;
    localparam logic [3:0] CODE_TX_ABORT = 4'h9;
    localparam logic [3:0] CODE_TX_DATA = 4'hC;
    localparam logic [3:0] CODE_ANSWER_SEND = 4'hE;
    localparam logic [3:0] CODE_BUSY_MASK = 4'h1;
    typedef enum logic [1:0] {
        CMBX_IDLE = 2'b00,
        CMBX_BUSY = 2'b01,
        CMBX_DONE = 2'b11
    } cmbx_upd_t;
    function automatic logic [3:0] cmbx_code(input logic [31:0] w0);
        return w0[CMBX_CODE_MSB:CMBX_CODE_LSB];
    endfunction : cmbx_code
endpackage : cmbx_pkg
`default_nettype wire

// *** cmbx_if.sv ***
// interface between mailbox code logic and the protocol engine
// assumes one clock; events are one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
interface cmbx_if #(parameter int MB_N = 4) (input wire logic core_clk);
    logic [MB_N-1:0] rx_eligible;
    logic [MB_N-1:0] tx_eligible;
    logic [MB_N-1:0] tx_remote;
    logic rx_done;
    logic rx_remote;
    logic [$clog2(MB_N)-1:0] rx_mb;
    logic tx_done;
    logic [$clog2(MB_N)-1:0] tx_mb;
    modport dev (input rx_done, rx_remote, rx_mb, tx_done, tx_mb,
                 output rx_eligible, tx_eligible, tx_remote);
    modport eng (output rx_done, rx_remote, rx_mb, tx_done, tx_mb,
                 input rx_eligible, tx_eligible, tx_remote);
endinterface : cmbx_if
`default_nettype wire

// *** cmbx_engine.sv ***
// protocol engine end: picks eligible mailboxes, reports move-in and sent frames
// assumes user side supplies received frames as pulses with a remote flag and a target mailbox index
`timescale 1ns/1ps
`default_nettype none
module cmbx_engine #(
    parameter int MB_N = 4
) (
    input wire logic core_clk,
    input wire logic reset,
    cmbx_if.eng link,
    input wire logic frame_rx,
    input wire logic frame_rx_remote,
    input wire logic [$clog2(MB_N)-1:0] frame_rx_mb,
    input wire logic tx_go,
    output logic tx_sent,
    output logic tx_sent_remote,
    output logic frame_dropped
);
    import cmbx_pkg::*;
    localparam int IW = $clog2(MB_N);

    // ---------------------------------------------------
    // arbitration: lowest eligible index wins
    // ---------------------------------------------------
    logic [IW-1:0] arb_idx;
    logic arb_any;
    always_comb begin
        arb_idx = '0;
        arb_any = 1'b0;
        for (int i = MB_N - 1; i >= 0; i--) begin
            if (link.tx_eligible[i]) begin
                arb_idx = IW'(i);
                arb_any = 1'b1;
            end
        end
    end

    wire rx_ok = frame_rx && link.rx_eligible[frame_rx_mb];
    wire tx_fire = tx_go && arb_any;

    assign link.rx_done = rx_ok;
    assign link.rx_remote = frame_rx_remote;
    assign link.rx_mb = frame_rx_mb;
    assign link.tx_done = tx_fire;
    assign link.tx_mb = arb_idx;

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            tx_sent <= 1'b0;
            tx_sent_remote <= 1'b0;
            frame_dropped <= 1'b0;
        end else begin
            tx_sent <= tx_fire;
            tx_sent_remote <= tx_fire && link.tx_remote[arb_idx];
            frame_dropped <= frame_rx && !rx_ok;
        end
    end
endmodule : cmbx_engine
`default_nettype wire

// *** cmbx_device.sv ***
// mailbox code state logic: one code per mailbox, updated by cpu and engine
// assumes cpu writes code and remote bit directly; no bus added
`timescale 1ns/1ps
`default_nettype none
module cmbx_device #(
    parameter int MB_N = 4
) (
    input wire logic core_clk,
    input wire logic reset,
    cmbx_if.dev link,
    input wire logic remote_request_store_select,
    input wire logic tx_busy_visibility_ctrl,
    input wire logic cpu_wr,
    input wire logic [$clog2(MB_N)-1:0] cpu_mb,
    input wire logic [31:0] cpu_wdata,
    input wire logic cpu_rd,
    input wire logic timer_rd,
    output logic [3:0] cpu_code,
    output logic [MB_N-1:0] cpu_rtr
);
    import cmbx_pkg::*;
    localparam int IW = $clog2(MB_N);

    logic [3:0] code [MB_N];
    logic [MB_N-1:0] rtr;
    logic [MB_N-1:0] fd_flag;
    logic [MB_N-1:0] serviced;
    logic [MB_N-1:0] locked;
    logic [MB_N-1:0] busy;

    // ---------------------------------------------------
    // eligibility seen by the engine
    // ---------------------------------------------------
    genvar g;
    for (g = 0; g < MB_N; g++) begin : g_elig
        wire answer_code;
        wire is_rx_code;
        wire answer_live;
        wire rx_role;
        wire tx_role;
        // the answer-wait code is receive-side for matching, but only while
        // the store select bit leaves remote requests to the mailboxes
        assign answer_code = code[g] == CODE_ANSWER_WAIT;
        assign is_rx_code = !code[g][3] || answer_code;
        assign answer_live = answer_code && !remote_request_store_select;
        assign rx_role = is_rx_code && code[g] != CODE_RX_INACTIVE
            && (!answer_code || answer_live);
        // inactive and abort transmit codes never reach arbitration
        assign tx_role = code[g] == CODE_TX_DATA
            || code[g] == CODE_ANSWER_SEND;
        // busy hides the mailbox from both sides for the cycle after an engine event on it
        assign link.rx_eligible[g] = !busy[g] && rx_role;
        assign link.tx_eligible[g] = !busy[g] && tx_role;
        assign link.tx_remote[g] = rtr[g];
    end

    // ---------------------------------------------------
    // next code after a move-in or a send
    // ---------------------------------------------------
    function automatic logic [3:0] rx_next(input logic [3:0] c, input logic srv,
                                           input logic rmt);
        logic [3:0] n;
        n = c;
        unique case (c)
            CODE_RX_EMPTY: n = CODE_RX_FULL;
            CODE_RX_FULL: n = srv ? CODE_RX_FULL : CODE_RX_OVERRUN;
            CODE_RX_OVERRUN: n = srv ? CODE_RX_FULL : CODE_RX_OVERRUN;
            CODE_ANSWER_WAIT: n = rmt ? CODE_ANSWER_SEND : CODE_ANSWER_WAIT;
            default: n = c;
        endcase
        return n;
    endfunction : rx_next

    function automatic logic [3:0] tx_next(input logic [3:0] c, input logic r);
        logic [3:0] n;
        n = c;
        if (c == CODE_ANSWER_SEND) begin
            n = CODE_ANSWER_WAIT;
        end else if (c == CODE_TX_DATA) begin
            n = r ? CODE_RX_EMPTY : CODE_TX_INACTIVE;
        end
        return n;
    endfunction : tx_next

    // ---------------------------------------------------
    // per mailbox code update; busy stands one cycle after an event
    // ---------------------------------------------------
    for (g = 0; g < MB_N; g++) begin : g_mb
        wire cw;
        wire rx_hit;
        wire tx_hit;
        wire own_rd;
        wire unlock;
        wire cpu_takes;
        wire [3:0] next_code;
        wire next_rtr;
        wire next_fd_flag;
        wire next_serviced;
        wire next_locked;
        assign cw = cpu_wr && cpu_mb == IW'(g);
        assign rx_hit = link.rx_done && link.rx_mb == IW'(g);
        assign tx_hit = link.tx_done && link.tx_mb == IW'(g);
        assign own_rd = cpu_rd && cpu_mb == IW'(g);
        // a read of a different mailbox or the timer releases the lock
        assign unlock = locked[g] && (timer_rd || (cpu_rd && cpu_mb != IW'(g)));
        // engine events win over a cpu write in the same cycle; the write is lost,
        // so software must not rewrite a mailbox that is still in play
        assign cpu_takes = cw && !rx_hit && !tx_hit;
        assign next_code = rx_hit ? rx_next(code[g], serviced[g], link.rx_remote)
            : tx_hit ? tx_next(code[g], rtr[g])
            : cpu_takes ? cmbx_code(cpu_wdata) : code[g];
        assign next_rtr = cpu_takes ? cpu_wdata[CMBX_RTR_BIT] : rtr[g];
        // the fd flag is only kept; its use with the answer codes is up to software
        assign next_fd_flag = cpu_takes ? cpu_wdata[CMBX_FD_FLAG_BIT] : fd_flag[g];
        // a move-in consumes the service; an unlock in that same cycle comes too late
        assign next_serviced = rx_hit ? 1'b0
            : (unlock && !own_rd) ? 1'b1 : serviced[g];
        assign next_locked = own_rd ? 1'b1 : unlock ? 1'b0 : locked[g];
        always_ff @(posedge core_clk or posedge reset) begin
            if (reset) begin
                code[g] <= CODE_RX_INACTIVE;
                rtr[g] <= 1'b0;
                fd_flag[g] <= 1'b0;
                serviced[g] <= 1'b0;
                locked[g] <= 1'b0;
                busy[g] <= 1'b0;
            end else begin
                busy[g] <= rx_hit || tx_hit;
                code[g] <= next_code;
                rtr[g] <= next_rtr;
                fd_flag[g] <= next_fd_flag;
                serviced[g] <= next_serviced;
                locked[g] <= next_locked;
            end
        end
    end

    // ---------------------------------------------------
    // cpu view of the selected code
    // ---------------------------------------------------
    wire [3:0] sel_code = code[cpu_mb];
    wire sel_tx = sel_code[3] && sel_code != CODE_ANSWER_WAIT;
    // tx busy hidden unless visibility is on
    wire show_busy = busy[cpu_mb] && (!sel_tx || tx_busy_visibility_ctrl);
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            cpu_code <= CODE_RX_INACTIVE;
            cpu_rtr <= '0;
        end else begin
            cpu_code <= sel_code | (show_busy ? CODE_BUSY_MASK : 4'h0);
            cpu_rtr <= rtr;
        end
    end
endmodule : cmbx_device
`default_nettype wire

// *** cmbx_link_monitor_monitor.sv ***
// checker on the link between the mailbox code logic and the engine
// assumes one clock and an active high reset shared by both ends
`timescale 1ns/1ps
`default_nettype none
module cmbx_link_monitor #(
    parameter int MB_N = 4
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [MB_N-1:0] rx_eligible,
    input wire logic [MB_N-1:0] tx_eligible,
    input wire logic [MB_N-1:0] tx_remote,
    input wire logic rx_done,
    input wire logic rx_remote,
    input wire logic [$clog2(MB_N)-1:0] rx_mb,
    input wire logic tx_done,
    input wire logic [$clog2(MB_N)-1:0] tx_mb
);
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    rx_target_a: assert property (rx_done |-> rx_eligible[rx_mb])
        else $error("move-in to an ineligible mailbox");
    rx_busy_a: assert property (rx_done |=> !rx_eligible[$past(rx_mb)])
        else $error("updated mailbox still matchable");
    tx_target_a: assert property (tx_done |-> tx_eligible[tx_mb])
        else $error("sent from a mailbox outside arbitration");
    tx_leaves_a: assert property (tx_done |=> !tx_eligible[$past(tx_mb)])
        else $error("sent mailbox stays in arbitration");
    one_role_a: assert property (!(|(rx_eligible & tx_eligible)))
        else $error("mailbox in matching and arbitration");
    rx_repeat_a: assert property (rx_done ##1 rx_done |-> rx_mb != $past(rx_mb))
        else $error("busy mailbox hit twice");
    tx_repeat_a: assert property (tx_done ##1 tx_done |-> tx_mb != $past(tx_mb))
        else $error("mailbox sent twice in a row");
    tx_busy_a: assert property (tx_done |=> !rx_eligible[$past(tx_mb)])
        else $error("mailbox matchable right after send");
    cover property (rx_done && rx_remote);
    cover property (tx_done && tx_remote[tx_mb]);
    cover property (rx_done ##1 rx_done);
endmodule : cmbx_link_monitor
`default_nettype wire

// *** can_mailbox_code_fsm_bench.sv ***
// bench joining both ends; drives cpu and engine user sides
// assumes 50 MHz core_clk; inputs change on the falling edge
`timescale 1ns/1ps
`default_nettype none
module can_mailbox_code_fsm_bench;
    import cmbx_pkg::*;
    logic core_clk, reset, sel, cpu_wr, cpu_rd, timer_rd, frame_rx, f_rem, tx_go;
    logic [1:0] cpu_mb, f_mb;
    logic [31:0] wdata;
    logic [3:0] cpu_code, pre;
    logic [3:0] model [4];
    logic srv [4];
    logic tx_sent, tx_rem, dropped, seen_drop, seen_busy;
    logic vis = 1'b0;
    logic [15:0] seed = 16'h0003;
    int errors = 0;
    int samples_checked = 0;
    cmbx_if #(.MB_N(4)) link (.core_clk(core_clk));
    cmbx_device #(.MB_N(4)) u_cmbx_device (.core_clk(core_clk), .reset(reset), .link(link),
        .remote_request_store_select(sel), .tx_busy_visibility_ctrl(vis), .cpu_wr(cpu_wr),
        .cpu_mb(cpu_mb), .cpu_wdata(wdata), .cpu_rd(cpu_rd), .timer_rd(timer_rd),
        .cpu_code(cpu_code), .cpu_rtr());
    cmbx_engine #(.MB_N(4)) u_cmbx_engine (.core_clk(core_clk), .reset(reset), .link(link),
        .frame_rx(frame_rx), .frame_rx_remote(f_rem), .frame_rx_mb(f_mb), .tx_go(tx_go),
        .tx_sent(tx_sent), .tx_sent_remote(tx_rem), .frame_dropped(dropped));
    cmbx_link_monitor #(.MB_N(4)) u_cmbx_link_monitor (.core_clk(core_clk), .reset(reset),
        .rx_eligible(link.rx_eligible), .tx_eligible(link.tx_eligible),
        .tx_remote(link.tx_remote), .rx_done(link.rx_done), .rx_remote(link.rx_remote),
        .rx_mb(link.rx_mb), .tx_done(link.tx_done), .tx_mb(link.tx_mb));
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    function automatic logic [3:0] after_rx(input logic [3:0] c, input logic s, input logic r);
        case (c)
            CODE_RX_EMPTY: return CODE_RX_FULL;
            CODE_RX_FULL, CODE_RX_OVERRUN: return s ? CODE_RX_FULL : CODE_RX_OVERRUN;
            CODE_ANSWER_WAIT: return (r && !sel) ? CODE_ANSWER_SEND : c;
            default: return c;
        endcase
    endfunction : after_rx
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic report_and_stop;
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : report_and_stop
    task automatic wr(input logic [1:0] mb, input logic [3:0] code, input logic rtr);
        @(negedge core_clk);
        cpu_wr = 1'b1;
        cpu_mb = mb;
        wdata = {4'h0, code, 3'h0, rtr, 20'h0_0000};
        @(negedge core_clk);
        cpu_wr = 1'b0;
        model[mb] = code;
    endtask : wr
    // a read only counts once the lock moves on, so every visit ends with a timer read
    task automatic serve(input logic [1:0] mb, input logic other);
        @(negedge core_clk);
        cpu_rd = 1'b1;
        cpu_mb = mb;
        srv[mb] = 1'b1;
        if (other) begin
            @(negedge core_clk);
            cpu_mb = mb + 2'd1;
            srv[mb + 2'd1] = 1'b1;
        end
        @(negedge core_clk);
        cpu_rd = 1'b0;
        timer_rd = 1'b1;
        @(negedge core_clk);
        timer_rd = 1'b0;
    endtask : serve
    task automatic rx(input logic [1:0] mb, input logic rem);
        logic drop;
        drop = model[mb] == CODE_RX_INACTIVE || (model[mb] == CODE_ANSWER_WAIT && sel);
        @(negedge core_clk);
        frame_rx = 1'b1;
        f_rem = rem;
        f_mb = mb;
        cpu_mb = mb;
        @(negedge core_clk);
        frame_rx = 1'b0;
        seen_drop = 1'b0;
        seen_busy = 1'b0;
        repeat (5) begin
            seen_drop |= dropped;
            seen_busy |= cpu_code[0];
            @(negedge core_clk);
        end
        check(seen_drop, drop);
        model[mb] = after_rx(model[mb], srv[mb], rem);
        srv[mb] = 1'b0;
        check(cpu_code, model[mb]);
    endtask : rx
    task automatic tx(input logic sent, input logic rem, input logic [1:0] mb,
                      input logic [3:0] code);
        logic s;
        logic r;
        @(negedge core_clk);
        tx_go = 1'b1;
        cpu_mb = mb;
        @(negedge core_clk);
        tx_go = 1'b0;
        s = 1'b0;
        r = 1'b0;
        seen_busy = 1'b0;
        repeat (6) begin
            if (tx_sent) r = tx_rem;
            s |= tx_sent;
            seen_busy |= cpu_code[0];
            @(negedge core_clk);
        end
        model[mb] = code;
        check(s, sent);
        check(r, rem);
        check(cpu_code, code);
    endtask : tx
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    initial begin
        #200_000;
        errors++;
        report_and_stop();
    end
    initial begin
        {reset, sel, cpu_wr, cpu_rd, timer_rd, frame_rx, f_rem, tx_go} = 8'h80;
        {cpu_mb, f_mb, wdata} = 36'h0_0000_0000;
        repeat (8) @(negedge core_clk);
        reset = 1'b0;
        for (int i = 0; i < 4; i++) begin
            wr(2'(i), CODE_RX_EMPTY, 1'b0);
            srv[i] = 1'b0;
        end
        repeat (3) rx(2'd0, 1'b0);
        serve(2'd0, 1'b0);
        rx(2'd0, 1'b0);
        repeat (60) begin
            seed = lfsr(seed);
            case (seed[3:2])
                2'd0: serve(seed[1:0], seed[4]);
                2'd1: wr(seed[1:0], seed[5] ? CODE_RX_EMPTY : CODE_RX_INACTIVE, 1'b0);
                default: begin
                    pre = model[seed[1:0]];
                    rx(seed[1:0], 1'b0);
                    check(seen_busy, pre != CODE_RX_INACTIVE);
                end
            endcase
        end
        wr(2'd0, CODE_TX_INACTIVE, 1'b0);
        wr(2'd1, CODE_TX_ABORT, 1'b0);
        wr(2'd2, CODE_TX_DATA, 1'b0);
        wr(2'd3, CODE_RX_INACTIVE, 1'b0);
        tx(1'b1, 1'b0, 2'd2, CODE_TX_INACTIVE);
        check(seen_busy, 1'b0);
        tx(1'b0, 1'b0, 2'd1, CODE_TX_ABORT);
        wr(2'd2, CODE_TX_DATA, 1'b1);
        tx(1'b1, 1'b1, 2'd2, CODE_RX_EMPTY);
        wr(2'd3, CODE_ANSWER_SEND, 1'b1);
        tx(1'b1, 1'b1, 2'd3, CODE_ANSWER_WAIT);
        rx(2'd3, 1'b1);
        tx(1'b1, 1'b1, 2'd3, CODE_ANSWER_WAIT);
        sel = 1'b1;
        rx(2'd3, 1'b1);
        tx(1'b0, 1'b0, 2'd3, CODE_ANSWER_WAIT);
        vis = 1'b1;
        wr(2'd2, CODE_TX_DATA, 1'b0);
        tx(1'b1, 1'b0, 2'd2, CODE_TX_INACTIVE);
        check(seen_busy, 1'b1);
        report_and_stop();
    end
endmodule : can_mailbox_code_fsm_bench
`default_nettype wire
